/* lsc_cfg.svh */
// Register map, field positions and state codes of the line state controller
`ifndef LSC_CFG_SVH
`define LSC_CFG_SVH
`define LSC_ADR_CTRL0     8'h00
`define LSC_ADR_CTRL1     8'h04
`define LSC_ADR_STAT0     8'h08
`define LSC_ADR_STAT1     8'h0c
`define LSC_ADR_INIT      8'h10
`define LSC_STATE_LSB     0
`define LSC_STATE_MSB     3
`define LSC_REV_BIT       4
`define LSC_TERM_BIT      5
`define LSC_CONV_BIT      6
`define LSC_EVCLR_BIT     8
`define LSC_INIT_DEV_BIT  0
`define LSC_INIT_LINE0    1
`define LSC_INIT_LINE1    2
`define LSC_STAT_GS_BIT   0
`define LSC_STAT_HEV_BIT  1
`define LSC_STAT_HOOK_BIT 2
`define LSC_STAT_GKEY_BIT 3
`define LSC_STAT_OV_BIT   4
`define LSC_STAT_CF_BIT   5
`define LSC_CODE_OFF      4'h0
`define LSC_CODE_OPEN     4'h1
`define LSC_CODE_IDLE     4'h2
`define LSC_CODE_GSW      4'h3
`define LSC_CODE_OHT      4'h4
`define LSC_CODE_FED      4'h5
`define LSC_CODE_PCM      4'h6
`define LSC_CODE_RING     4'h7
`define LSC_CODE_HOWL     4'h8
`endif

/* lsc_pkg.sv */
// Types shared by the line state controller
package lsc_pkg;
    typedef enum logic [8:0] {
        state_off               = 9'h001,
        state_line_open         = 9'h002,
        state_idle_onhook       = 9'h004,
        state_ground_start_wait = 9'h008,
        state_onhook_transmit   = 9'h010,
        state_fed_no_pcm        = 9'h020,
        state_fed_with_pcm      = 9'h040,
        state_ringing           = 9'h080,
        state_howler            = 9'h100
    } lsc_line_e;

    typedef struct packed {
        logic dc_feed;
        logic hook_sup;
        logic voice;
        logic pcm;
        logic reg_on;
        logic reg_floor;
        logic tip_hiz;
        logic ring_hiz;
        logic ring_voc;
        logic power_saving_idle;
        logic reverse;
    } lsc_ctl_s;
endpackage : lsc_pkg

/* lsc_line_ctrl.sv */
// Dual channel line state controller with classic Wishbone slave
`timescale 1ns/10ps
`include "lsc_cfg.svh"

// Operation
// - Seventeen states per channel: nine base states plus reverse-polarity variants of all but off.
// - Device or line initialization leaves affected channels in line open.
// - Reset enters off: shutdown, voice off, regulator off, no signaling.
// - Battery overvoltage or clock fault forces channel into off state.
// - Line open: drivers high impedance, regulator on at floor voltage.
// - Line open: voice off unless converter configuration enables monitoring.
// - Normal termination idle: feed, hook supervision, open circuit voltage, voice off.
// - Power saving idle: feed off, ring voltage, off-hook monitored, voice off.
// - Onhook transmit: feed on, voice on, hook supervision on.
// - Both fed states: feed and supervision; PCM only with pcm state.
// - Transmit and fed states: regulator makes only the needed high voltage.
// - Ground start wait: tip open, ring at voc, ground key raises event.
module lsc_line_ctrl
    import lsc_pkg::*;
#(
    parameter int NCH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic [NCH-1:0]   batt_ov_i,
    input  wire logic             clk_fault_i,
    input  wire logic [NCH-1:0]   off_hook_i,
    input  wire logic [NCH-1:0]   gnd_key_i,
    output lsc_ctl_s  [NCH-1:0]   line_ctl_o,
    output logic      [NCH-1:0]   gnd_start_evt_o,
    output logic      [NCH-1:0]   hook_evt_o
);

    // Base state code to one-hot state
    function automatic lsc_line_e decode_state(input logic [3:0] c);
        case (c)
            `LSC_CODE_OFF:  decode_state = state_off;
            `LSC_CODE_OPEN: decode_state = state_line_open;
            `LSC_CODE_IDLE: decode_state = state_idle_onhook;
            `LSC_CODE_GSW:  decode_state = state_ground_start_wait;
            `LSC_CODE_OHT:  decode_state = state_onhook_transmit;
            `LSC_CODE_FED:  decode_state = state_fed_no_pcm;
            `LSC_CODE_PCM:  decode_state = state_fed_with_pcm;
            `LSC_CODE_RING: decode_state = state_ringing;
            `LSC_CODE_HOWL: decode_state = state_howler;
            default:        decode_state = state_off;
        endcase
    endfunction : decode_state

    function automatic logic [3:0] encode_state(input lsc_line_e s);
        case (s)
            state_line_open:         encode_state = `LSC_CODE_OPEN;
            state_idle_onhook:       encode_state = `LSC_CODE_IDLE;
            state_ground_start_wait: encode_state = `LSC_CODE_GSW;
            state_onhook_transmit:   encode_state = `LSC_CODE_OHT;
            state_fed_no_pcm:        encode_state = `LSC_CODE_FED;
            state_fed_with_pcm:      encode_state = `LSC_CODE_PCM;
            state_ringing:           encode_state = `LSC_CODE_RING;
            state_howler:            encode_state = `LSC_CODE_HOWL;
            default:                 encode_state = `LSC_CODE_OFF;
        endcase
    endfunction : encode_state

    // Pin synchronisers
    logic [NCH-1:0] ov_m_q, ov_s_q, hk_m_q, hk_s_q, gk_m_q, gk_s_q;
    logic           cf_m_q, cf_s_q;
    logic [NCH-1:0] hk_prev_q, gk_prev_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ov_m_q    <= '0;
            ov_s_q    <= '0;
            hk_m_q    <= '0;
            hk_s_q    <= '0;
            gk_m_q    <= '0;
            gk_s_q    <= '0;
            cf_m_q    <= 1'b0;
            cf_s_q    <= 1'b0;
            hk_prev_q <= '0;
            gk_prev_q <= '0;
        end else begin
            ov_m_q    <= batt_ov_i;
            ov_s_q    <= ov_m_q;
            hk_m_q    <= off_hook_i;
            hk_s_q    <= hk_m_q;
            gk_m_q    <= gnd_key_i;
            gk_s_q    <= gk_m_q;
            cf_m_q    <= clk_fault_i;
            cf_s_q    <= cf_m_q;
            hk_prev_q <= hk_s_q;
            gk_prev_q <= gk_s_q;
        end
    end

    // Per-channel state, options and sticky events
    lsc_line_e [NCH-1:0] st_q, st_d;
    logic      [NCH-1:0] rev_q, rev_d, term_q, term_d, conv_q, conv_d;
    logic      [NCH-1:0] gs_q, gs_d, hev_q, hev_d;
    lsc_ctl_s  [NCH-1:0] ctl_q, ctl_d;
    logic      [31:0]    dat_d, dat_q;
    logic                ack_d, ack_q;
    logic                wr;

    // Write lands at the edge that sees ack high
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];

    always_comb begin
        st_d   = st_q;
        rev_d  = rev_q;
        term_d = term_q;
        conv_d = conv_q;
        gs_d   = gs_q;
        hev_d  = hev_q;
        for (int c = 0; c < NCH; c++) begin
            if (wr && wb_adr_i == (c == 0 ? `LSC_ADR_CTRL0 : `LSC_ADR_CTRL1)) begin
                st_d[c]   = decode_state(wb_dat_i[`LSC_STATE_MSB:`LSC_STATE_LSB]);
                rev_d[c]  = wb_dat_i[`LSC_REV_BIT];
                term_d[c] = wb_dat_i[`LSC_TERM_BIT];
                conv_d[c] = wb_dat_i[`LSC_CONV_BIT];
                if (wb_sel_i[1] && wb_dat_i[`LSC_EVCLR_BIT]) begin
                    gs_d[c]  = 1'b0;
                    hev_d[c] = 1'b0;
                end
            end else if (wr && wb_adr_i == `LSC_ADR_INIT) begin
                if (wb_dat_i[`LSC_INIT_DEV_BIT] ||
                    wb_dat_i[c == 0 ? `LSC_INIT_LINE0 : `LSC_INIT_LINE1]) begin
                    st_d[c]  = state_line_open;
                    rev_d[c] = 1'b0;
                end
            end
            if (ov_s_q[c] || cf_s_q) begin
                st_d[c] = state_off;
            end
            // Set wins over clear
            if (st_q[c] == state_ground_start_wait && gk_s_q[c] && !gk_prev_q[c]) begin
                gs_d[c] = 1'b1;
            end
            if (ctl_q[c].hook_sup && hk_s_q[c] != hk_prev_q[c]) begin
                hev_d[c] = 1'b1;
            end
        end
    end

    // Line control outputs from state
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            ctl_d[c]         = '0;
            ctl_d[c].reverse = rev_q[c];
            case (st_q[c])
                state_off: begin
                    ctl_d[c].reverse = 1'b0;
                end
                state_line_open: begin
                    ctl_d[c].reg_on    = 1'b1;
                    ctl_d[c].reg_floor = 1'b1;
                    ctl_d[c].tip_hiz   = 1'b1;
                    ctl_d[c].ring_hiz  = 1'b1;
                    ctl_d[c].voice     = conv_q[c];
                end
                state_idle_onhook: begin
                    ctl_d[c].reg_on = 1'b1;
                    if (term_q[c]) begin
                        ctl_d[c].power_saving_idle = 1'b1;
                        ctl_d[c].ring_voc          = 1'b1;
                        ctl_d[c].hook_sup          = 1'b1;
                        ctl_d[c].tip_hiz           = 1'b1;
                    end else begin
                        ctl_d[c].dc_feed  = 1'b1;
                        ctl_d[c].hook_sup = 1'b1;
                        ctl_d[c].ring_voc = 1'b1;
                    end
                end
                state_ground_start_wait: begin
                    ctl_d[c].reg_on   = 1'b1;
                    ctl_d[c].tip_hiz  = 1'b1;
                    ctl_d[c].ring_voc = 1'b1;
                end
                state_onhook_transmit: begin
                    ctl_d[c].reg_on   = 1'b1;
                    ctl_d[c].dc_feed  = 1'b1;
                    ctl_d[c].voice    = 1'b1;
                    ctl_d[c].hook_sup = 1'b1;
                end
                state_fed_no_pcm, state_fed_with_pcm: begin
                    ctl_d[c].reg_on   = 1'b1;
                    ctl_d[c].dc_feed  = 1'b1;
                    ctl_d[c].hook_sup = 1'b1;
                    ctl_d[c].voice    = 1'b1;
                    ctl_d[c].pcm      = (st_q[c] == state_fed_with_pcm);
                end
                state_ringing: begin
                    ctl_d[c].reg_on   = 1'b1;
                    ctl_d[c].voice    = 1'b1;
                    ctl_d[c].hook_sup = 1'b1;
                end
                state_howler: begin
                    ctl_d[c].reg_on  = 1'b1;
                    ctl_d[c].dc_feed = 1'b1;
                    ctl_d[c].voice   = 1'b1;
                end
                default: begin
                    ctl_d[c] = '0;
                end
            endcase
        end
    end

    // Wishbone read data and single-cycle ack
    function automatic logic [31:0] ctrl_word(input int c);
        ctrl_word = '0;
        ctrl_word[`LSC_STATE_MSB:`LSC_STATE_LSB] = encode_state(st_q[c]);
        ctrl_word[`LSC_REV_BIT]  = rev_q[c];
        ctrl_word[`LSC_TERM_BIT] = term_q[c];
        ctrl_word[`LSC_CONV_BIT] = conv_q[c];
    endfunction : ctrl_word

    function automatic logic [31:0] stat_word(input int c);
        stat_word    = '0;
        stat_word[`LSC_STAT_GS_BIT]   = gs_q[c];
        stat_word[`LSC_STAT_HEV_BIT]  = hev_q[c];
        stat_word[`LSC_STAT_HOOK_BIT] = hk_s_q[c];
        stat_word[`LSC_STAT_GKEY_BIT] = gk_s_q[c];
        stat_word[`LSC_STAT_OV_BIT]   = ov_s_q[c];
        stat_word[`LSC_STAT_CF_BIT]   = cf_s_q;
    endfunction : stat_word

    always_comb begin
        ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
        dat_d = '0;
        if (wb_adr_i == `LSC_ADR_CTRL0) begin
            dat_d = ctrl_word(0);
        end else if (wb_adr_i == `LSC_ADR_CTRL1) begin
            dat_d = ctrl_word(1);
        end else if (wb_adr_i == `LSC_ADR_STAT0) begin
            dat_d = stat_word(0);
        end else if (wb_adr_i == `LSC_ADR_STAT1) begin
            dat_d = stat_word(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int c = 0; c < NCH; c++) begin
                st_q[c] <= state_off;
            end
            rev_q  <= '0;
            term_q <= '0;
            conv_q <= '0;
            gs_q   <= '0;
            hev_q  <= '0;
            ctl_q  <= '0;
            dat_q  <= '0;
            ack_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            rev_q  <= rev_d;
            term_q <= term_d;
            conv_q <= conv_d;
            gs_q   <= gs_d;
            hev_q  <= hev_d;
            ctl_q  <= ctl_d;
            dat_q  <= dat_d;
            ack_q  <= ack_d;
        end
    end

    assign wb_dat_o        = dat_q;
    assign wb_ack_o        = ack_q;
    assign line_ctl_o      = ctl_q;
    assign gnd_start_evt_o = gs_q;
    assign hook_evt_o      = hev_q;

endmodule : lsc_line_ctrl

/* lsc_line_ctrl_assertions.sv */
// Output checker for the line state controller
`timescale 1ns/10ps
module lsc_line_ctrl_assertions
    import lsc_pkg::*;
#(parameter int NCH = 2) (
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               wb_ack_o,
    input wire logic [NCH-1:0]     batt_ov_i,
    input wire logic               clk_fault_i,
    input wire lsc_ctl_s [NCH-1:0] line_ctl_o,
    input wire logic [NCH-1:0]     gnd_start_evt_o
);
    lsc_ctl_s c0;
    assign c0 = line_ctl_o[0];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_clk_bad; clk_fault_i [*6]; endsequence
    sequence s_batt_bad; batt_ov_i[0] [*6]; endsequence
    property p_reset_off;
        disable iff (1'b0) rst_i |=> line_ctl_o == '0 && !wb_ack_o;
    endproperty
    property p_clk_off; s_clk_bad |-> line_ctl_o == '0; endproperty
    property p_batt_off; s_batt_bad |-> line_ctl_o[0] == '0; endproperty
    property p_open_reg;
        c0.tip_hiz && c0.ring_hiz |-> c0.reg_on && c0.reg_floor && !c0.dc_feed;
    endproperty
    property p_pcm_fed; c0.pcm |-> c0.dc_feed && c0.hook_sup; endproperty
    property p_psi; c0.power_saving_idle |-> !c0.dc_feed && !c0.voice; endproperty
    property p_rev; c0.reverse |-> c0[10:1] != '0; endproperty
    property p_gnd_evt;
        $rose(gnd_start_evt_o[0]) |-> c0.tip_hiz && c0.ring_voc;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("reset not off");
    a_clk_off: assert property (p_clk_off) else $error("clock fault not off");
    a_batt_off: assert property (p_batt_off) else $error("overvoltage not off");
    a_open_reg: assert property (p_open_reg) else $error("open regulator");
    a_pcm_fed: assert property (p_pcm_fed) else $error("pcm without feed");
    a_psi: assert property (p_psi) else $error("power saving fed");
    a_rev: assert property (p_rev) else $error("reverse in off");
    a_gnd_evt: assert property (p_gnd_evt) else $error("ground event state");
endmodule : lsc_line_ctrl_assertions

bind lsc_line_ctrl lsc_line_ctrl_assertions #(.NCH(NCH)) u_chk (
    .clk_i, .rst_i, .wb_ack_o, .batt_ov_i, .clk_fault_i, .line_ctl_o, .gnd_start_evt_o);

/* lsc_host_model.sv */
// Host processor model driving the Wishbone register port
`timescale 1ns/10ps
module lsc_host_model (
    input  wire logic        clk_i,
    input  wire logic        wb_ack_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_cyc_o,
    output logic             wb_stb_o,
    output logic             wb_we_o,
    output logic [7:0]       wb_adr_o,
    output logic [3:0]       wb_sel_o,
    output logic [31:0]      wb_dat_o
);
    initial begin
        {wb_cyc_o, wb_stb_o, wb_we_o, wb_sel_o} = '0;
        wb_adr_o = 8'hff;
        wb_dat_o = 32'h0;
    end
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              input logic [3:0] s, output logic [31:0] q);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= w;
        wb_adr_o <= a;
        wb_sel_o <= s;
        wb_dat_o <= d;
        do @(posedge clk_i); while (wb_ack_i !== 1'b1);
        q = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        // Released bus shows no stale value
        wb_adr_o <= ~a;
        wb_dat_o <= ~d;
        @(posedge clk_i);
    endtask : xfer
endmodule : lsc_host_model

/* lsc_line_ctrl_tb.sv */
// Self-checking bench for the line state controller
`timescale 1ns/10ps
`include "lsc_cfg.svh"
module lsc_line_ctrl_tb
    import lsc_pkg::*;
;
    logic clk_i = 0, rst_i = 1, cyc, stb, we, ack, cfault = 0;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat, rdo;
    logic [1:0] batt = 0, hook = 0, gkey = 0, gev, hev;
    lsc_ctl_s [1:0] ctl;
    int err_count = 0, cmp_count = 0, cyc_n = 0;
    logic [7:0] wd [12] = '{8'h01, 8'h41, 8'h02, 8'h22, 8'h03, 8'h14,
                            8'h05, 8'h16, 8'h00, 8'h17, 8'h18, 8'h19};
    logic [10:0] wm [12] = '{11'h579, 11'h579, 11'h703, 11'h503, 11'h01d, 11'h761,
                             11'h6e1, 11'h6e1, 11'h7ff, 11'h001, 11'h001, 11'h7ff};
    logic [10:0] we_x [12] = '{11'h078, 11'h178, 11'h600, 11'h002, 11'h014, 11'h741,
                               11'h640, 11'h6c1, 11'h000, 11'h001, 11'h001, 11'h000};
    always #20 clk_i = ~clk_i;
    lsc_line_ctrl #(.NCH(2)) uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdo),
        .wb_ack_o(ack), .batt_ov_i(batt), .clk_fault_i(cfault), .off_hook_i(hook),
        .gnd_key_i(gkey), .line_ctl_o(ctl), .gnd_start_evt_o(gev), .hook_evt_o(hev));
    lsc_host_model u_host (.clk_i, .wb_ack_i(ack), .wb_dat_i(rdo), .wb_cyc_o(cyc),
        .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dat));
    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task cc(input int ch, input logic [10:0] m, input logic [10:0] e);
        chk({21'h0, ctl[ch] & m}, {21'h0, e});
    endtask : cc
    task wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, 4'h3, rdat);
        repeat (2) @(posedge clk_i);
    endtask : wr
    task rd(input logic [7:0] a);
        u_host.xfer(1'b0, a, 32'h0, 4'hf, rdat);
    endtask : rd
    task tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task t_reset;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({9'h0, ack, ctl}, 32'h0);
    endtask : t_reset
    task t_init;
        wr(`LSC_ADR_INIT, 32'h1);
        cc(0, 11'h579, 11'h078);
        cc(1, 11'h579, 11'h078);
        wr(`LSC_ADR_CTRL0, 32'h5);
        wr(`LSC_ADR_CTRL1, 32'h5);
        wr(`LSC_ADR_INIT, 32'h4);
        cc(0, 11'h681, 11'h600);
        cc(1, 11'h579, 11'h078);
        wr(`LSC_ADR_INIT, 32'h2);
        cc(0, 11'h579, 11'h078);
    endtask : t_init
    task t_states;
        for (int i = 0; i < 12; i++) begin
            wr(`LSC_ADR_CTRL0, {24'h0, wd[i]});
            cc(0, wm[i], we_x[i]);
        end
        cc(1, 11'h579, 11'h078);
    endtask : t_states
    task t_faults;
        wr(`LSC_ADR_CTRL0, 32'h5);
        wr(`LSC_ADR_CTRL1, 32'h5);
        batt <= 2'b01;
        repeat (6) @(posedge clk_i);
        cc(0, 11'h7ff, 11'h000);
        cc(1, 11'h681, 11'h600);
        rd(`LSC_ADR_STAT0);
        chk({31'h0, rdat[4]}, 32'h1);
        batt <= 2'b00;
        cfault <= 1'b1;
        repeat (7) @(posedge clk_i);
        chk({10'h0, ctl}, 32'h0);
        cfault <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : t_faults
    task t_events;
        wr(`LSC_ADR_CTRL0, 32'h3);
        gkey <= 2'b01;
        repeat (5) @(posedge clk_i);
        chk({31'h0, gev[0]}, 32'h1);
        gkey <= 2'b00;
        repeat (4) @(posedge clk_i);
        wr(`LSC_ADR_CTRL0, 32'h105);
        chk({30'h0, gev}, 32'h0);
        gkey <= 2'b01;
        hook <= 2'b01;
        repeat (5) @(posedge clk_i);
        chk({30'h0, gev[0], hev[0]}, 32'h1);
        rd(`LSC_ADR_STAT0);
        chk({28'h0, rdat[3:0]}, 32'he);
        rd(8'h20);
        chk(rdat, 32'h0);
        rd(`LSC_ADR_INIT);
        chk(rdat, 32'h0);
    endtask : t_events
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 3000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        t_reset();
        t_init();
        t_states();
        t_faults();
        t_events();
        tally_and_finish();
    end
endmodule : lsc_line_ctrl_tb
